// ### common/sdc_pkg.sv
package sdc_pkg;

   // ------------------------------------------------------------
   // divider layout
   // ------------------------------------------------------------
   localparam int unsigned SDC_DIV_STAGES = 3;
   localparam int unsigned SDC_BIT_TWO    = 0;
   localparam int unsigned SDC_BIT_FOUR   = 1;
   localparam int unsigned SDC_BIT_EIGHT  = 2;

   localparam logic [SDC_DIV_STAGES-1:0] SDC_COUNT_RESET = 3'h0;
   localparam logic [SDC_DIV_STAGES-1:0] SDC_COUNT_STEP  = 3'h1;

   // ------------------------------------------------------------
   // reset release: rising edges skipped before the first toggle
   // ------------------------------------------------------------
   localparam int unsigned SDC_SKIP_W = 2;
   localparam logic [SDC_SKIP_W-1:0] SDC_SKIP_CLK_HIGH = 2'h1;
   localparam logic [SDC_SKIP_W-1:0] SDC_SKIP_CLK_LOW  = 2'h2;
   localparam logic [SDC_SKIP_W-1:0] SDC_SKIP_NONE     = 2'h0;
   localparam logic [SDC_SKIP_W-1:0] SDC_SKIP_ONE      = 2'h1;

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   localparam int unsigned SDC_SYNC_STAGES = 3;

   typedef struct packed {
      logic clk_in;
      logic sync_reset;
      logic freeze;
   } sdc_pins_type;

   localparam sdc_pins_type SDC_PINS_RESET = '{clk_in: 1'h0, sync_reset: 1'h1, freeze: 1'h0};

   typedef enum logic [1:0] {
      SDC_HOLD,
      SDC_WAIT,
      SDC_RUN
   } sdc_state_type;

endpackage : sdc_pkg

// ### rtl/sdc_divider.sv
// Behaviour
// - reset released with clock high: outputs first toggle on second rising edge
// - reset released with clock low: outputs first toggle on third rising edge
// - freeze input high stops dividers from the first falling clock edge after
// - while frozen with divider_sync_reset low every divider flip-flop holds its state
// - freeze low takes effect at next falling edge, counting resumes in phase
`timescale 1ns/100ps
module sdc_divider
   import sdc_pkg::*;
#(
   parameter int unsigned SYNC_STAGES = SDC_SYNC_STAGES
)
(
   // system
   input  wire logic sys_clk,
   input  wire logic resetn,
   // device pins
   input  wire logic clk_in,
   input  wire logic divider_sync_reset,
   input  wire logic freeze_req,
   // divided outputs
   output logic      out_div_two,
   output logic      out_div_four,
   output logic      out_div_eight
);

   // ------------------------------------------------------------
   // edge helpers
   // ------------------------------------------------------------
   // high now and low one cycle ago
   function automatic logic went_high(input logic now_level, input logic was_level);
      return now_level & ~was_level;
   endfunction : went_high

   // low now and high one cycle ago
   function automatic logic went_low(input logic now_level, input logic was_level);
      return ~now_level & was_level;
   endfunction : went_low

   // ------------------------------------------------------------
   // pin synchroniser and filter
   // ------------------------------------------------------------
   sdc_pins_type sync_pipe [SYNC_STAGES];
   sdc_pins_type pins;
   sdc_pins_type next_pins;
   sdc_pins_type raw_pins;

   assign raw_pins = '{clk_in: clk_in, sync_reset: divider_sync_reset, freeze: freeze_req};

   always_comb begin
      next_pins = pins;
      // a change counts once the last two stages agree
      if (sync_pipe[SYNC_STAGES-2] == sync_pipe[SYNC_STAGES-1]) begin
         next_pins = sync_pipe[SYNC_STAGES-1];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_pipe[i] <= SDC_PINS_RESET;
         end
         pins <= SDC_PINS_RESET;
      end else begin
         sync_pipe[0] <= raw_pins;
         // each stage reads only the one before it
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_pipe[i] <= sync_pipe[i-1];
         end
         pins <= next_pins;
      end
   end

   // ------------------------------------------------------------
   // filtered pin edges
   // ------------------------------------------------------------
   logic clk_rise;
   logic clk_fall;
   logic reset_release;

   // edges are taken between the filtered value and its next value
   assign clk_rise      = went_high(next_pins.clk_in, pins.clk_in);
   assign clk_fall      = went_low(next_pins.clk_in, pins.clk_in);
   assign reset_release = went_low(next_pins.sync_reset, pins.sync_reset);

   // ------------------------------------------------------------
   // freeze flip-flop, loaded on falling input clock edges only
   // ------------------------------------------------------------
   logic frozen;
   logic next_frozen;

   always_comb begin
      next_frozen = frozen;
      if (clk_fall) begin
         next_frozen = next_pins.freeze;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         frozen <= 1'h0;
      end else begin
         frozen <= next_frozen;
      end
   end

   // ------------------------------------------------------------
   // start control after master reset release
   // ------------------------------------------------------------
   sdc_state_type                state;
   sdc_state_type                next_state;
   logic [SDC_SKIP_W-1:0]        skip;
   logic [SDC_SKIP_W-1:0]        next_skip;

   always_comb begin
      next_state = state;
      next_skip  = skip;
      unique case (state)
         SDC_HOLD: begin
            if (reset_release) begin
               if (pins.clk_in) begin
                  next_skip = SDC_SKIP_CLK_HIGH;
               end else begin
                  next_skip = SDC_SKIP_CLK_LOW;
               end
               next_state = SDC_WAIT;
            end
         end
         SDC_WAIT: begin
            if (clk_rise) begin
               if (skip == SDC_SKIP_ONE) begin
                  next_state = SDC_RUN;
               end
               next_skip = skip - SDC_SKIP_ONE;
            end
         end
         SDC_RUN: begin
            // counting itself lives in the counter group
            next_state = SDC_RUN;
         end
         default: begin
            // an unused code waits for the master reset again
            next_state = SDC_HOLD;
            next_skip  = SDC_SKIP_NONE;
         end
      endcase
      if (next_pins.sync_reset) begin
         next_state = SDC_HOLD;
         next_skip  = SDC_SKIP_NONE;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= SDC_HOLD;
         skip  <= SDC_SKIP_NONE;
      end else begin
         state <= next_state;
         skip  <= next_skip;
      end
   end

   // ------------------------------------------------------------
   // divider counter
   // ------------------------------------------------------------
   logic [SDC_DIV_STAGES-1:0]    count;
   logic [SDC_DIV_STAGES-1:0]    next_count;

   always_comb begin
      next_count = count;
      if (state == SDC_RUN && clk_rise && !frozen) begin
         next_count = count + SDC_COUNT_STEP;
      end
      // held at zero until the start control lets it run
      if (state == SDC_HOLD || next_pins.sync_reset) begin
         next_count = SDC_COUNT_RESET;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count <= SDC_COUNT_RESET;
      end else begin
         count <= next_count;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // loaded from the counter's next value, so all three change together
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_div_two   <= SDC_COUNT_RESET[SDC_BIT_TWO];
         out_div_four  <= SDC_COUNT_RESET[SDC_BIT_FOUR];
         out_div_eight <= SDC_COUNT_RESET[SDC_BIT_EIGHT];
      end else begin
         out_div_two   <= next_count[SDC_BIT_TWO];
         out_div_four  <= next_count[SDC_BIT_FOUR];
         out_div_eight <= next_count[SDC_BIT_EIGHT];
      end
   end

endmodule : sdc_divider

// ### testbench/sdc_clock_source.sv
`timescale 1ns/100ps
module sdc_clock_source (
   input  wire logic sys_clk,
   output logic      clk_in
);
   logic [2:0] ph = 3'h0;
   initial clk_in = 1'b0;
   // free running input clock, ten system cycles a period
   always @(posedge sys_clk)
      if (ph == 3'h4) begin
         ph <= 3'h0;
         clk_in <= !clk_in;
      end else
         ph <= ph + 3'h1;
endmodule : sdc_clock_source

// ### testbench/sdc_divider_monitor.sv
`timescale 1ns/100ps
module sdc_divider_monitor (
   // system
   input wire logic sys_clk,
   input wire logic resetn,
   // pins
   input wire logic clk_in,
   input wire logic divider_sync_reset,
   input wire logic freeze_req,
   // outputs
   input wire logic out_div_two,
   input wire logic out_div_four,
   input wire logic out_div_eight
);
   logic [2:0] cnt;
   assign cnt = {out_div_eight, out_div_four, out_div_two};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   chk_start_high: assert property ($fell(divider_sync_reset) && clk_in |->
      (cnt == 3'h0)[*8] ##[1:25] cnt == 3'h1) else $error("bad start, clock high");
   chk_start_low: assert property ($fell(divider_sync_reset) && !clk_in |->
      (cnt == 3'h0)[*8] ##[5:30] cnt == 3'h1) else $error("bad start, clock low");
   chk_freeze_start: assert property ($rose(freeze_req) && clk_in |->
      ##8 $stable(cnt)[*8]) else $error("count moved after freeze");
   chk_frozen_hold: assert property (freeze_req[*8] ##1 freeze_req[*8] ##1
      freeze_req[*8] |-> $stable(cnt)) else $error("count moved while frozen");
   chk_resume_step: assert property ($fell(freeze_req) && !divider_sync_reset |->
      ##[1:40] $changed(cnt)) else $error("no resume");
   chk_count_step: assert property ($changed(cnt) && !divider_sync_reset |->
      cnt == $past(cnt) + 3'h1) else $error("divider stages out of step");
endmodule : sdc_divider_monitor

// ### testbench/sdc_divider_test.sv
`timescale 1ns/100ps
module sdc_divider_test;
   logic sys_clk, resetn, clk_in, divider_sync_reset, freeze_req, q2, q4, q8;
   logic [2:0] exp_cnt;
   int n_mismatch = 0, n_checks = 0, seed = 55679, n;
   sdc_clock_source src (.sys_clk(sys_clk), .clk_in(clk_in));
   sdc_divider uut (.sys_clk(sys_clk), .resetn(resetn), .clk_in(clk_in),
      .divider_sync_reset(divider_sync_reset), .freeze_req(freeze_req),
      .out_div_two(q2), .out_div_four(q4), .out_div_eight(q8));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = !sys_clk;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   function automatic logic [2:0] after(int k, int skip);
      return (k > skip) ? 3'(k - skip) : 3'h0;
   endfunction : after
   task automatic edge_chk(input logic [2:0] want);
      @(posedge clk_in);
      repeat (8) @(posedge sys_clk);
      n_checks++;
      if ({q8, q4, q2} !== want) begin
         n_mismatch++;
         $display("wrong value at %0t: %h expected %h", $time, {q8, q4, q2}, want);
      end
   endtask : edge_chk
   // each call waits for one input clock edge: rising when hi is set, falling otherwise
   task automatic at_phase(input logic hi);
      if (hi) @(posedge clk_in);
      else @(negedge clk_in);
      repeat (2) @(posedge sys_clk);
   endtask : at_phase
   initial begin
      resetn = 1'b0;
      divider_sync_reset = 1'b1;
      freeze_req = 1'b0;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int ph = 0; ph < 2; ph++) begin
         divider_sync_reset <= 1'b1;
         edge_chk(3'h0);
         at_phase(ph == 0);
         divider_sync_reset <= 1'b0;
         n = 9 + $unsigned($random(seed)) % 8;
         for (int k = 1; k <= n; k++)
            edge_chk(after(k, ph + 1));
      end
      exp_cnt = after(n, 2);
      for (int c = 0; c < 4; c++) begin
         at_phase(c[0]);
         exp_cnt = exp_cnt + 3'h1 + {2'h0, !c[0]};
         freeze_req <= 1'b1;
         edge_chk(exp_cnt);
         repeat (1 + $unsigned($random(seed)) % 4) edge_chk(exp_cnt);
         at_phase(c[1]);
         freeze_req <= 1'b0;
         exp_cnt = exp_cnt + {2'h0, c[1]};
         edge_chk(exp_cnt);
         exp_cnt = exp_cnt + 3'h1;
         edge_chk(exp_cnt);
      end
      test_done;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      test_done;
   end
endmodule : sdc_divider_test
bind sdc_divider sdc_divider_monitor mon (.sys_clk(sys_clk), .resetn(resetn), .clk_in(clk_in),
   .divider_sync_reset(divider_sync_reset), .freeze_req(freeze_req),
   .out_div_two(out_div_two), .out_div_four(out_div_four), .out_div_eight(out_div_eight));
